// File: lbmc_top.sv
// Function
// RULE1: Writing AA to the bank pointer at 1F switches later accesses to the expanded bank.
// RULE2: Writing 00 to the bank pointer while expanded switches later accesses back to the primary bank.
// RULE3: Expanded addresses 08 to 1E are test registers resetting to zero, which the host leaves alone.
// RULE4: Expanded addresses 00 to 07 hold the eight per-port control masks in their fixed order.
// RULE5: With the master clock static the transmit path runs from port 1's transmit clock, receive status still follows the master clock.
// RULE6: With neither the master clock nor port 1's transmit clock toggling, all tip and ring outputs float.
// RULE7: Global control bit 2 alone sets the attenuator corner, one giving 6.5 Hz, FIFO depth ignored.
// RULE8: In hardware mode the attenuator corner is fixed, ignoring the bandwidth bit and FIFO depth.
// RULE9: In hardware mode each loopback pin gives remote when low, analog when high, none at mid supply.
// RULE10: In hardware mode the placement pin puts the attenuator in transmit when low, receive when high, off at mid supply, undefined when floating.
// RULE11: A write to the soft reset register at 0A returns every register to its default.
// RULE12: The soft reset register reads FF after reset.
// RULE13: Bank pointer values other than AA or 00 leave the bank unchanged, and 1F is the pointer in both banks.
// RULE14: All registers are eight bits wide and the bank selection resets to primary.
`timescale 1ns/1ps
`default_nettype none

module lbmc_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [lbmc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lbmc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lbmc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic master_clock,
  input wire logic port1_transmit_clock,
  input wire logic hw_mode,
  input wire logic [2*lbmc_pkg::PORTS-1:0] loopback_select_pin,
  input wire logic [1:0] attenuator_placement_pin,
  input wire logic [lbmc_pkg::PORTS-1:0] tx_tip_data,
  input wire logic [lbmc_pkg::PORTS-1:0] tx_ring_data,
  output logic [lbmc_pkg::PORTS-1:0] transmit_line_tip_out,
  output logic [lbmc_pkg::PORTS-1:0] transmit_line_tip_oe,
  output logic [lbmc_pkg::PORTS-1:0] transmit_line_ring_out,
  output logic [lbmc_pkg::PORTS-1:0] transmit_line_ring_oe,
  output logic tx_clock_from_port1,
  output logic rx_master_clock_ok,
  output logic attenuator_corner_select,
  output logic [lbmc_pkg::PORTS-1:0] remote_loopback,
  output logic [lbmc_pkg::PORTS-1:0] analog_loopback,
  output logic attenuator_in_tx,
  output logic attenuator_in_rx,
  output logic attenuator_placement_valid,
  output logic expanded_bank_active,
  output logic [lbmc_pkg::DATA_W-1:0] single_rail_mode_select,
  output logic [lbmc_pkg::DATA_W-1:0] line_code_select,
  output logic [lbmc_pkg::DATA_W-1:0] clock_recovery_enable,
  output logic [lbmc_pkg::DATA_W-1:0] receiver_power_down,
  output logic [lbmc_pkg::DATA_W-1:0] transmitter_power_down,
  output logic [lbmc_pkg::DATA_W-1:0] zero_run_detect_enable,
  output logic [lbmc_pkg::DATA_W-1:0] violation_detect_enable,
  output logic [lbmc_pkg::DATA_W-1:0] equalizer_enable
);
  import lbmc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Default value of a primary register by offset
  function automatic logic [7:0] primary_default(input int unsigned idx);
    begin
      primary_default = (idx == int'(OFS_SOFT_RESET)) ? RST_SOFT_RESET : RST_DEFAULT;
    end
  endfunction

  // Three-level pin decode, shared by loopback and placement pins
  function automatic logic [2:0] level_decode(input logic [1:0] code);
    begin
      // Returns {low, high, mid}; float gives all zero
      unique case (lbmc_level_e'(code))
        LVL_LOW: level_decode = 3'h4;
        LVL_HIGH: level_decode = 3'h2;
        LVL_MID: level_decode = 3'h1;
        LVL_FLOAT: level_decode = 3'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] primary_reg [PRIMARY_COUNT];
  logic [7:0] expanded_reg [EXP_COUNT];
  logic [7:0] bank_pointer_reg;
  logic bank_sel_reg;
  logic bank_sel_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic hit_pointer = (reg_addr == OFS_BANK_POINTER); // [RULE13]
  wire logic hit_primary = !bank_sel_reg && (reg_addr <= OFS_PRIMARY_LAST);
  wire logic hit_expanded = bank_sel_reg && !hit_pointer;
  wire logic soft_reset_hit = reg_wr && hit_primary && (reg_addr == OFS_SOFT_RESET);
  wire logic wr_primary = reg_wr && hit_primary && !soft_reset_hit;
  wire logic wr_expanded = reg_wr && hit_expanded;
  wire logic wr_pointer = reg_wr && hit_pointer;
  // Full reset path: pin reset or software reset write
  wire logic regs_clear = sys_rst || soft_reset_hit; // [RULE11]

  // ----------------------------------------------------------------
  // Bank selection
  // ----------------------------------------------------------------

  // Only the two magic values move the bank; anything else keeps it
  always_comb begin
    bank_sel_next = bank_sel_reg;
    if (wr_pointer && reg_wdata == BANK_SEL_EXPANDED) begin
      bank_sel_next = 1'b1; // [RULE1]
    end else if (wr_pointer && reg_wdata == BANK_SEL_PRIMARY) begin
      bank_sel_next = 1'b0; // [RULE2]
    end
  end

  // Pointer and bank flag, both cleared by soft reset too
  always_ff @(posedge clk) begin
    if (regs_clear) begin
      bank_sel_reg <= 1'b0; // [RULE14]
      bank_pointer_reg <= RST_BANK_POINTER;
    end else begin
      bank_sel_reg <= bank_sel_next; // [RULE13]
      if (wr_pointer) begin
        bank_pointer_reg <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Primary bank
  // ----------------------------------------------------------------

  // Soft reset write restores defaults, itself back to FF
  always_ff @(posedge clk) begin
    for (int unsigned i = 0; i < PRIMARY_COUNT; i++) begin
      if (regs_clear) begin
        primary_reg[i] <= primary_default(i); // [RULE11] [RULE12]
      end else if (wr_primary && reg_addr == 5'(i)) begin
        primary_reg[i] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Expanded bank
  // ----------------------------------------------------------------

  // Controls at 00-07 and test registers at 08-1E, all zero at reset
  always_ff @(posedge clk) begin
    for (int unsigned i = 0; i < EXP_COUNT; i++) begin
      if (regs_clear) begin
        expanded_reg[i] <= RST_DEFAULT; // [RULE3] [RULE11]
      end else if (wr_expanded && reg_addr == 5'(i)) begin
        expanded_reg[i] <= reg_wdata; // [RULE4]
      end
    end
  end

  // Control masks in fixed offset order
  assign single_rail_mode_select = expanded_reg[0]; // [RULE4]
  assign line_code_select = expanded_reg[1];
  assign clock_recovery_enable = expanded_reg[2];
  assign receiver_power_down = expanded_reg[3];
  assign transmitter_power_down = expanded_reg[4];
  assign zero_run_detect_enable = expanded_reg[5];
  assign violation_detect_enable = expanded_reg[6];
  assign equalizer_enable = expanded_reg[7];
  assign expanded_bank_active = bank_sel_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Reserved primary offsets read zero; data valid one cycle only
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      if (hit_pointer) begin
        rdata_next = bank_pointer_reg;
      end else if (hit_primary) begin
        rdata_next = primary_reg[reg_addr];
      end else if (hit_expanded) begin
        rdata_next = expanded_reg[reg_addr];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Clock activity monitors
  // ----------------------------------------------------------------
  logic mclk_prev_reg;
  logic tclk_prev_reg;
  logic [LOSS_CNT_W-1:0] mclk_idle_reg;
  logic [LOSS_CNT_W-1:0] tclk_idle_reg;
  localparam logic [LOSS_CNT_W-1:0] LOSS_LIMIT = LOSS_CNT_W'(CLK_LOSS_CYCLES);

  wire logic mclk_edge = master_clock ^ mclk_prev_reg;
  wire logic tclk_edge = port1_transmit_clock ^ tclk_prev_reg;
  // A clock is taken as static after the loss time with no edge
  wire logic mclk_active = (mclk_idle_reg < LOSS_LIMIT);
  wire logic tclk_active = (tclk_idle_reg < LOSS_LIMIT);

  // Idle counters saturate; starting saturated keeps line off until a clock shows
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mclk_prev_reg <= 1'b0;
      tclk_prev_reg <= 1'b0;
      mclk_idle_reg <= LOSS_LIMIT;
      tclk_idle_reg <= LOSS_LIMIT;
    end else begin
      mclk_prev_reg <= master_clock;
      tclk_prev_reg <= port1_transmit_clock;
      if (mclk_edge) begin
        mclk_idle_reg <= '0;
      end else if (mclk_active) begin
        mclk_idle_reg <= mclk_idle_reg + 1'b1;
      end
      if (tclk_edge) begin
        tclk_idle_reg <= '0;
      end else if (tclk_active) begin
        tclk_idle_reg <= tclk_idle_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit clock fallback and line drive
  // ----------------------------------------------------------------
  wire logic tx_clock_ok = mclk_active || tclk_active; // [RULE6]
  logic tx_from_port1_reg;
  logic rx_ok_reg;
  logic [PORTS-1:0] tip_reg;
  logic [PORTS-1:0] ring_reg;
  logic [PORTS-1:0] line_oe_reg;

  // Receive status tracks the real master clock, never the fallback
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_from_port1_reg <= 1'b0;
      rx_ok_reg <= 1'b0;
      tip_reg <= '0;
      ring_reg <= '0;
      line_oe_reg <= '0;
    end else begin
      tx_from_port1_reg <= !mclk_active; // [RULE5]
      rx_ok_reg <= mclk_active; // [RULE5]
      tip_reg <= tx_tip_data;
      ring_reg <= tx_ring_data;
      line_oe_reg <= {PORTS{tx_clock_ok}}; // [RULE6]
    end
  end

  assign tx_clock_from_port1 = tx_from_port1_reg;
  assign rx_master_clock_ok = rx_ok_reg;
  assign transmit_line_tip_out = tip_reg;
  assign transmit_line_ring_out = ring_reg;
  assign transmit_line_tip_oe = line_oe_reg;
  assign transmit_line_ring_oe = line_oe_reg;

  // ----------------------------------------------------------------
  // Attenuator corner frequency
  // ----------------------------------------------------------------

  // Only the bandwidth bit matters; FIFO depth is deliberately not an input
  wire logic host_corner = primary_reg[OFS_GLOBAL_CONTROL][GC_BANDWIDTH_BIT]; // [RULE7]
  wire logic corner_next = hw_mode ? HW_CORNER_SELECT : host_corner; // [RULE8]
  logic corner_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      corner_reg <= 1'b0;
    end else begin
      corner_reg <= corner_next;
    end
  end

  assign attenuator_corner_select = corner_reg;

  // ----------------------------------------------------------------
  // Hardware-mode pin decode
  // ----------------------------------------------------------------
  logic [PORTS-1:0] remote_next;
  logic [PORTS-1:0] analog_next;
  logic [PORTS-1:0] remote_reg;
  logic [PORTS-1:0] analog_reg;
  logic [2:0] lp_lvl;

  // Per-port loopback; a floating pin falls into no loopback
  always_comb begin
    remote_next = '0;
    analog_next = '0;
    lp_lvl = 3'h0;
    for (int unsigned p = 0; p < PORTS; p++) begin
      lp_lvl = level_decode(loopback_select_pin[2*p +: 2]);
      remote_next[p] = hw_mode && lp_lvl[2]; // [RULE9]
      analog_next[p] = hw_mode && lp_lvl[1]; // [RULE9]
    end
  end

  // Placement pin; float leaves the placement flagged invalid
  wire logic [2:0] ja_lvl = level_decode(attenuator_placement_pin);
  wire logic ja_tx_next = hw_mode && ja_lvl[2]; // [RULE10]
  wire logic ja_rx_next = hw_mode && ja_lvl[1]; // [RULE10]
  wire logic ja_valid_next = !hw_mode || (ja_lvl != 3'h0); // [RULE10]
  logic ja_tx_reg;
  logic ja_rx_reg;
  logic ja_valid_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      remote_reg <= '0;
      analog_reg <= '0;
      ja_tx_reg <= 1'b0;
      ja_rx_reg <= 1'b0;
      ja_valid_reg <= 1'b1;
    end else begin
      remote_reg <= remote_next;
      analog_reg <= analog_next;
      ja_tx_reg <= ja_tx_next;
      ja_rx_reg <= ja_rx_next;
      ja_valid_reg <= ja_valid_next;
    end
  end

  assign remote_loopback = remote_reg;
  assign analog_loopback = analog_reg;
  assign attenuator_in_tx = ja_tx_reg;
  assign attenuator_in_rx = ja_rx_reg;
  assign attenuator_placement_valid = ja_valid_reg;

endmodule

`default_nettype wire

// File: lbmc_pkg.sv
package lbmc_pkg;

  // ----------------------------------------------------------------
  // Widths and port count
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned PORTS = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_SOFT_RESET = 5'h0A;
  localparam logic [4:0] OFS_GLOBAL_CONTROL = 5'h0F;
  localparam logic [4:0] OFS_PRIMARY_LAST = 5'h15;
  localparam logic [4:0] OFS_BANK_POINTER = 5'h1F;
  localparam logic [4:0] OFS_EXP_CTRL_LAST = 5'h07;
  localparam logic [4:0] OFS_EXP_TEST_FIRST = 5'h08;
  localparam logic [4:0] OFS_EXP_TEST_LAST = 5'h1E;
  localparam int unsigned PRIMARY_COUNT = 22;
  localparam int unsigned EXP_COUNT = 31;

  // ----------------------------------------------------------------
  // Field positions and special values
  // ----------------------------------------------------------------
  localparam int unsigned GC_BANDWIDTH_BIT = 2;
  localparam logic [7:0] BANK_SEL_EXPANDED = 8'hAA;
  localparam logic [7:0] BANK_SEL_PRIMARY = 8'h00;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DEFAULT = 8'h00;
  localparam logic [7:0] RST_SOFT_RESET = 8'hFF;
  localparam logic [7:0] RST_BANK_POINTER = 8'h00;
  // Fixed hardware-mode corner select level (narrow corner)
  localparam logic HW_CORNER_SELECT = 1'b0;

  // ----------------------------------------------------------------
  // Three-level pin codes from the pad comparators
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_MID = 2'h1,
    LVL_FLOAT = 2'h2,
    LVL_HIGH = 2'h3
  } lbmc_level_e;

  // ----------------------------------------------------------------
  // Clock-loss timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CLK_LOSS_TIME_NS = 2000;
  localparam int unsigned CLK_LOSS_CYCLES = CLK_LOSS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned LOSS_CNT_W = 6;

endpackage

// File: lbmc_properties.sv
`timescale 1ns/1ps
`default_nettype none

module lbmc_properties
  import lbmc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic master_clock,
  input wire logic port1_transmit_clock,
  input wire logic hw_mode,
  input wire logic [15:0] loopback_select_pin,
  input wire logic [1:0] attenuator_placement_pin,
  input wire logic [7:0] transmit_line_tip_oe,
  input wire logic [7:0] transmit_line_ring_oe,
  input wire logic tx_clock_from_port1,
  input wire logic rx_master_clock_ok,
  input wire logic attenuator_corner_select,
  input wire logic [7:0] remote_loopback,
  input wire logic [7:0] analog_loopback,
  input wire logic attenuator_in_tx,
  input wire logic attenuator_in_rx,
  input wire logic attenuator_placement_valid,
  input wire logic expanded_bank_active,
  input wire logic [7:0] single_rail_mode_select,
  input wire logic [7:0] equalizer_enable
);
  logic [5:0] mc_idle;
  logic [5:0] tc_idle;
  logic [7:0] lb_rem;
  logic [7:0] lb_ana;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Idle counts saturate so a long stop never wraps back to zero
  always_ff @(posedge clk) begin
    if (sys_rst || !$stable(master_clock)) mc_idle <= 6'h00;
    else if (mc_idle != 6'h3F) mc_idle <= mc_idle + 6'h01;
    if (sys_rst || !$stable(port1_transmit_clock)) tc_idle <= 6'h00;
    else if (tc_idle != 6'h3F) tc_idle <= tc_idle + 6'h01;
  end

  // Expected loopback decode, one cycle behind the pins
  always_ff @(posedge clk) begin
    for (int p = 0; p < 8; p++) begin
      lb_rem[p] <= loopback_select_pin[2*p+:2] == 2'h0;
      lb_ana[p] <= loopback_select_pin[2*p+:2] == 2'h3;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_bank_to_expanded: assert property (
    reg_wr && reg_addr == 5'h1F && reg_wdata == 8'hAA |=> expanded_bank_active)
    else $error("bank did not switch to expanded");
  a_bank_to_primary: assert property (
    reg_wr && reg_addr == 5'h1F && reg_wdata == 8'h00 |=> !expanded_bank_active)
    else $error("bank did not switch to primary");
  a_bank_other_value: assert property (
    reg_wr && reg_addr == 5'h1F && reg_wdata != 8'hAA && reg_wdata != 8'h00
    |=> $stable(expanded_bank_active))
    else $error("bank changed on other pointer value");
  a_bank_reset_primary: assert property (
    $past(sys_rst) |-> !expanded_bank_active)
    else $error("bank not primary after reset");
  a_expanded_ctrl_order: assert property (
    expanded_bank_active && reg_wr |=>
    ($past(reg_addr) != 5'h00 || single_rail_mode_select == $past(reg_wdata)) &&
    ($past(reg_addr) != 5'h07 || equalizer_enable == $past(reg_wdata)))
    else $error("expanded control register misplaced");
  a_soft_reset_all: assert property (
    reg_wr && !expanded_bank_active && reg_addr == 5'h0A |=>
    !expanded_bank_active && single_rail_mode_select == 8'h00 && equalizer_enable == 8'h00)
    else $error("soft reset left state behind");
  a_tx_fallback: assert property (
    mc_idle >= 6'd24 |-> tx_clock_from_port1 && !rx_master_clock_ok)
    else $error("no transmit fallback with master clock static");
  a_tx_high_z: assert property (
    mc_idle >= 6'd24 && tc_idle >= 6'd24 |->
    transmit_line_tip_oe == 8'h00 && transmit_line_ring_oe == 8'h00)
    else $error("line driven with both clocks static");
  a_corner_host: assert property (
    reg_wr && !expanded_bank_active && reg_addr == 5'h0F && !hw_mode ##1 !reg_wr && !hw_mode
    |=> attenuator_corner_select == $past(reg_wdata[2], 2))
    else $error("corner select not from control bit");
  a_corner_fixed: assert property (
    $past(hw_mode) && !$past(sys_rst) |-> attenuator_corner_select == HW_CORNER_SELECT)
    else $error("corner select not fixed in hardware mode");
  a_loopback_decode: assert property (
    $past(hw_mode) && !$past(sys_rst) |-> remote_loopback == lb_rem && analog_loopback == lb_ana)
    else $error("loopback pin decode wrong");
  a_placement_decode: assert property (
    $past(hw_mode) && !$past(sys_rst) |->
    attenuator_in_tx == ($past(attenuator_placement_pin) == 2'h0) &&
    attenuator_in_rx == ($past(attenuator_placement_pin) == 2'h3) &&
    attenuator_placement_valid == ($past(attenuator_placement_pin) != 2'h2))
    else $error("placement pin decode wrong");
endmodule

`default_nettype wire

// File: lbmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module lbmc_host_model (
  input wire logic clk,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Idle bus before the first request
  initial begin
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write; callers never aim at test registers 08..1E
  // Returns mid-cycle so callers see the state the write just launched
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule

`default_nettype wire

// File: lbmc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module lbmc_top_tb;
  import lbmc_pkg::*;
  logic clk, sys_rst, hw_mode, master_clock, port1_transmit_clock, mclk_run, tclk_run;
  logic reg_wr, reg_rd;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [15:0] loopback_select_pin, pins;
  logic [1:0] attenuator_placement_pin;
  logic [7:0] tx_tip_data, tx_ring_data, transmit_line_tip_out, transmit_line_tip_oe;
  logic [7:0] transmit_line_ring_out, transmit_line_ring_oe, remote_loopback, analog_loopback;
  logic tx_clock_from_port1, rx_master_clock_ok, attenuator_corner_select, attenuator_in_tx;
  logic attenuator_in_rx, attenuator_placement_valid, expanded_bank_active;
  logic [7:0] single_rail_mode_select, line_code_select, clock_recovery_enable, receiver_power_down;
  logic [7:0] transmitter_power_down, zero_run_detect_enable, violation_detect_enable, equalizer_enable;
  logic [7:0] ctl [8];
  int fails, checks_done, cycles;

  lbmc_top u_dut (.*);
  lbmc_host_model u_host (.*);

  // Expanded controls in address order
  assign ctl = '{single_rail_mode_select, line_code_select, clock_recovery_enable, receiver_power_down,
    transmitter_power_down, zero_run_detect_enable, violation_detect_enable, equalizer_enable};

  // ----------------------------------------
  // Clock, line stimulus and timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Pin clocks toggle at half rate so the monitors see real edges
  always @(posedge clk) begin
    if (mclk_run) master_clock <= ~master_clock;
    if (tclk_run) port1_transmit_clock <= ~port1_transmit_clock;
    tx_tip_data <= tx_tip_data + 8'h01;
    tx_ring_data <= ~tx_tip_data;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic conclude;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {sys_rst, mclk_run, tclk_run, hw_mode, master_clock, port1_transmit_clock} = 6'b111000;
    {loopback_select_pin, attenuator_placement_pin, tx_tip_data, tx_ring_data} = '0;
    cycles = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    u_host.rd(5'h0A, v);
    chk(v, RST_SOFT_RESET);
    chk(8'(expanded_bank_active), 8'h00);
    u_host.wr(5'h1F, 8'h55);
    chk(8'(expanded_bank_active), 8'h00);
    u_host.wr(5'h1F, 8'hAA);
    chk(8'(expanded_bank_active), 8'h01);
    for (int i = 0; i < 8; i++) u_host.wr(5'(i), 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 8; i++) begin
      u_host.rd(5'(i), v);
      chk(v, 8'(8'h11 * (i + 1)));
      chk(ctl[i], 8'(8'h11 * (i + 1)));
    end
    u_host.rd(5'h08, v);
    chk(v, 8'h00);
    u_host.rd(5'h1E, v);
    chk(v, 8'h00);
    u_host.wr(5'h1F, 8'h5A);
    u_host.rd(5'h1F, v);
    chk({v[6:0], expanded_bank_active}, 8'hB5);
    u_host.wr(5'h1F, 8'h00);
    chk(8'(expanded_bank_active), 8'h00);
    $display("bank test done");
    u_host.wr(5'h0F, 8'h04);
    settle();
    chk(8'(attenuator_corner_select), 8'h01);
    u_host.wr(5'h0F, 8'hFB);
    settle();
    chk(8'(attenuator_corner_select), 8'h00);
    u_host.wr(5'h0F, 8'h04);
    @(posedge clk);
    hw_mode <= 1'b1;
    settle();
    chk(8'(attenuator_corner_select), 8'(HW_CORNER_SELECT));
    // Each port steps through all four pin codes over the passes; ports p and p+4 share a code
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 8; p++) pins[2*p+:2] = 2'(c + p);
      @(posedge clk);
      loopback_select_pin <= pins;
      attenuator_placement_pin <= 2'(c);
      settle();
      for (int p = 0; p < 8; p++) begin
        chk({remote_loopback[p], analog_loopback[p]}, {2'(c + p) == 2'h0, 2'(c + p) == 2'h3});
      end
      chk({attenuator_in_tx, attenuator_in_rx, attenuator_placement_valid}, {c == 0, c == 3, c != 2});
    end
    @(posedge clk);
    hw_mode <= 1'b0;
    $display("mode test done");
    u_host.wr(5'h1F, 8'hAA);
    u_host.wr(5'h07, 8'h5A);
    u_host.wr(5'h1F, 8'h00);
    u_host.wr(5'h0A, 8'h00);
    chk({equalizer_enable[6:0], expanded_bank_active}, 8'h00);
    u_host.rd(5'h0A, v);
    chk(v, RST_SOFT_RESET);
    u_host.wr(5'h1F, 8'hAA);
    u_host.rd(5'h07, v);
    chk(v, 8'h00);
    u_host.wr(5'h1F, 8'h00);
    $display("soft reset test done");
    chk({transmit_line_tip_oe[3:0], transmit_line_ring_oe[3:0]}, 8'hFF);
    @(posedge clk);
    mclk_run <= 1'b0;
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk({tx_clock_from_port1, rx_master_clock_ok, transmit_line_tip_oe[5:0]}, 8'hBF);
    chk(transmit_line_tip_out, tx_tip_data - 8'h01);
    chk(transmit_line_ring_out, tx_ring_data + 8'h01);
    @(posedge clk);
    tclk_run <= 1'b0;
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk(transmit_line_tip_oe | transmit_line_ring_oe, 8'h00);
    @(posedge clk);
    {mclk_run, tclk_run} <= 2'b11;
    settle();
    chk(transmit_line_tip_oe & transmit_line_ring_oe, 8'hFF);
    $display("clock test done");
    conclude();
  end
endmodule

bind lbmc_top lbmc_properties u_props (.*);

`default_nettype wire
